// [logic/sensor_offset_id_scratch_regs.sv]
// serial target, strap decode, offset/scratch/identity registers, averaging
// assumes the conversion engine delivers raw samples on i_clk and that
// the link clock runs free, well faster than the bus clock it samples
//
// Function
// - offset register is added to each linearized result
// - offset is 16 bits, result format, 7.8125 mdegC per bit
// - overflowing sum clamps to most positive or negative code
// - offset at 07h, read/write, resets to zero
// - scratch words are 16-bit read/write, loaded from stored data
// - identity at 0Fh is read-only: revision 15:12, part code 11:0
// - device is only a bus target and never starts transfers
// - strap tied to ground, supply, data or clock picks one of four addresses
// - limit event output flags results outside the programmed limits
// - averaging over 1, 8, 32 or 64 conversions
// - general-call reset restarts device in about 1.5 ms, then sampling
// - eight-sample average takes about 125 ms of conversion
// - scratch write programs stored copy only while unlocked
// - signed values are two's complement
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module serial_target_link
(
	input wire logic i_link_clk,
	input wire logic i_rstn,
	input wire logic i_scl_in,
	input wire logic i_sda_in,
	input wire logic i_addr_strap_pin,
	input wire logic i_ack_tog,
	input wire logic [15:0] i_rd_data,
	output logic o_pin_low,
	output logic o_sda_oe,
	output logic o_scl_oe,
	output logic o_req_tog,
	output logic o_req_wr,
	output logic o_req_gcr,
	output logic [7:0] o_req_addr,
	output logic [15:0] o_req_data
);
	typedef enum logic [3:0] {L_IDLE, L_ADDR, L_ACK_ADDR, L_WR, L_ACK_WR, L_RD_WAIT, L_RD,
		L_RD_ACK, L_RD_LOAD, L_IGNORE} link_st_t;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] strap_s;
		logic [1:0] ack_s;
		logic scl_d;
		logic sda_d;
		link_st_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic [1:0] byte_idx;
		logic rw;
		logic gcall;
		logic lsb_next;
		logic first_low;
		logic strap_idle;
		logic strap_start;
		logic strap_low;
		logic [7:0] ptr;
		logic [7:0] wdata_hi;
		logic [15:0] rdata;
		logic pin_low;
		logic sda_oe;
		logic scl_oe;
		logic req_tog;
		logic req_wr;
		logic req_gcr;
		logic [7:0] req_addr;
		logic [15:0] req_data;
	} link_state_t;

	link_state_t r;
	link_state_t next_r;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic pending;
	logic [6:0] dev_addr;

	// strap samples: idle (both lines high), after start, first clock low
	function automatic logic [6:0] strap_addr(input logic idle, input logic st,
		input logic low);
		logic [1:0] code;
		code = !idle ? sensor_regs_pkg::STRAP_GND :
			!st ? sensor_regs_pkg::STRAP_SDA :
			low ? sensor_regs_pkg::STRAP_VDD : sensor_regs_pkg::STRAP_SCL;
		return sensor_regs_pkg::TARGET_BASE + {5'h00, code};
	endfunction

	always_comb
	begin
		next_r = r;
		next_r.scl_s = {r.scl_s[0], i_scl_in};
		next_r.sda_s = {r.sda_s[0], i_sda_in};
		next_r.strap_s = {r.strap_s[0], i_addr_strap_pin};
		next_r.ack_s = {r.ack_s[0], i_ack_tog};
		next_r.scl_d = r.scl_s[1];
		next_r.sda_d = r.sda_s[1];
		scl = r.scl_s[1];
		sda = r.sda_s[1];
		rise = scl && !r.scl_d;
		fall = !scl && r.scl_d;
		start = scl && r.scl_d && r.sda_d && !sda;
		stop = scl && r.scl_d && !r.sda_d && sda;
		pending = r.req_tog != r.ack_s[1];
		dev_addr = strap_addr(r.strap_idle, r.strap_start, r.strap_low);
		// stretch the clock low while the core domain answers a request
		next_r.scl_oe = pending && (!scl || r.scl_oe);
		if (stop)
		begin
			next_r.st = L_IDLE;
			next_r.sda_oe = 1'b0;
		end
		else if (start)
		begin
			next_r.st = L_ADDR;
			next_r.bit_cnt = 4'h0;
			next_r.sda_oe = 1'b0;
			next_r.strap_start = r.strap_s[1];
			next_r.first_low = 1'b1;
		end
		else
		begin
			case (r.st)
				L_IDLE:
				begin
					if (scl && sda)
						next_r.strap_idle = r.strap_s[1];
				end
				L_ADDR:
				begin
					if (rise)
					begin
						next_r.shreg = {r.shreg[6:0], sda};
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
					if (fall && r.first_low)
					begin
						next_r.strap_low = r.strap_s[1];
						next_r.first_low = 1'b0;
					end
					if (fall && r.bit_cnt == 4'h8)
					begin
						// answer only to our address or a general-call write
						if (r.shreg[7:1] == dev_addr)
						begin
							next_r.sda_oe = 1'b1;
							next_r.rw = r.shreg[0];
							next_r.gcall = 1'b0;
							next_r.st = L_ACK_ADDR;
						end
						else if (r.shreg == sensor_regs_pkg::GCALL_WRITE)
						begin
							next_r.sda_oe = 1'b1;
							next_r.rw = 1'b0;
							next_r.gcall = 1'b1;
							next_r.st = L_ACK_ADDR;
						end
						else
							next_r.st = L_IGNORE;
					end
				end
				L_ACK_ADDR:
				begin
					if (fall)
					begin
						next_r.sda_oe = 1'b0;
						next_r.bit_cnt = 4'h0;
						next_r.byte_idx = 2'h0;
						if (r.rw)
						begin
							next_r.req_tog = !r.req_tog;
							next_r.req_wr = 1'b0;
							next_r.req_gcr = 1'b0;
							next_r.req_addr = r.ptr;
							next_r.st = L_RD_WAIT;
						end
						else
							next_r.st = L_WR;
					end
				end
				L_RD_WAIT:
				begin
					// read data is stable once the returned toggle is seen
					if (!pending)
					begin
						next_r.rdata = i_rd_data;
						next_r.shreg = i_rd_data[15:8];
						next_r.sda_oe = !i_rd_data[15];
						next_r.lsb_next = 1'b1;
						next_r.bit_cnt = 4'h0;
						next_r.st = L_RD;
					end
				end
				L_RD:
				begin
					if (rise)
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					if (fall && r.bit_cnt == 4'h8)
					begin
						next_r.sda_oe = 1'b0;
						next_r.st = L_RD_ACK;
					end
					else if (fall)
					begin
						next_r.shreg = {r.shreg[6:0], 1'b0};
						next_r.sda_oe = !r.shreg[6];
					end
				end
				L_RD_ACK:
				begin
					if (rise)
						next_r.st = sda ? L_IGNORE : L_RD_LOAD;
				end
				L_RD_LOAD:
				begin
					if (fall)
					begin
						next_r.shreg = r.lsb_next ? r.rdata[7:0] : r.rdata[15:8];
						next_r.sda_oe = r.lsb_next ? !r.rdata[7] : !r.rdata[15];
						next_r.lsb_next = !r.lsb_next;
						next_r.bit_cnt = 4'h0;
						next_r.st = L_RD;
					end
				end
				L_WR:
				begin
					if (rise)
					begin
						next_r.shreg = {r.shreg[6:0], sda};
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
					if (fall && r.bit_cnt == 4'h8)
					begin
						next_r.sda_oe = 1'b1;
						next_r.st = L_ACK_WR;
						if (r.gcall)
						begin
							if (r.shreg == sensor_regs_pkg::GCALL_RESET)
							begin
								next_r.req_tog = !r.req_tog;
								next_r.req_gcr = 1'b1;
								next_r.req_wr = 1'b0;
							end
						end
						else if (r.byte_idx == 2'h0)
						begin
							next_r.ptr = r.shreg;
							next_r.byte_idx = 2'h1;
						end
						else if (r.byte_idx == 2'h1)
						begin
							next_r.wdata_hi = r.shreg;
							next_r.byte_idx = 2'h2;
						end
						else
						begin
							next_r.req_tog = !r.req_tog;
							next_r.req_wr = 1'b1;
							next_r.req_gcr = 1'b0;
							next_r.req_addr = r.ptr;
							next_r.req_data = {r.wdata_hi, r.shreg};
							next_r.byte_idx = 2'h1;
						end
					end
				end
				L_ACK_WR:
				begin
					if (fall)
					begin
						next_r.sda_oe = 1'b0;
						next_r.bit_cnt = 4'h0;
						next_r.st = L_WR;
					end
				end
				L_IGNORE:
					next_r.sda_oe = 1'b0;
				default:
					next_r.st = L_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_link_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			r <= '0;
		else
			r <= next_r;
	end

	assign o_pin_low = r.pin_low;
	assign o_sda_oe = r.sda_oe;
	assign o_scl_oe = r.scl_oe;
	assign o_req_tog = r.req_tog;
	assign o_req_wr = r.req_wr;
	assign o_req_gcr = r.req_gcr;
	assign o_req_addr = r.req_addr;
	assign o_req_data = r.req_data;

	default clocking cb @(posedge i_link_clk); endclocking
	default disable iff (!i_rstn);

	addr_ack_a: assert property ((r.st == L_ADDR && fall && r.bit_cnt == 4'h8 &&
		r.shreg[7:1] == dev_addr && !start && !stop) |=> o_sda_oe ##1 o_sda_oe)
		else $error("own address not acknowledged");
	stretch_only_a: assert property (o_scl_oe |-> $past(pending))
		else $error("clock held low with no request outstanding");
	gcall_reset_a: assert property ((r.st == L_WR && r.gcall && fall &&
		r.bit_cnt == 4'h8 && r.shreg == sensor_regs_pkg::GCALL_RESET && !start && !stop)
		|=> (o_req_gcr && o_req_tog != $past(o_req_tog)))
		else $error("general-call reset not forwarded");
endmodule

////////////////////////////////////////////////////////////////////////////////
module sensor_offset_id_scratch_regs
#(
	parameter int GCR_CYCLES = sensor_regs_pkg::GCR_CYCLES,
	parameter int SAMPLE_CYCLES = sensor_regs_pkg::SAMPLE_CYCLES,
	parameter logic [3:0] REVISION = 4'h0,
	parameter logic [11:0] PART_CODE = 12'h5a3 // arbitrary value
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_link_clk,
	input wire logic i_scl_in,
	input wire logic i_sda_in,
	input wire logic i_addr_strap_pin,
	output logic o_scl_out,
	output logic o_scl_oe,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic [15:0] i_raw_temp,
	input wire logic i_raw_valid,
	output logic o_sample_req,
	input wire logic [1:0] i_avg_sel,
	input wire logic [15:0] i_high_limit,
	input wire logic [15:0] i_low_limit,
	output logic o_limit_event,
	input wire logic i_nvm_write_enable,
	input wire logic [15:0] i_nvm_word_a,
	input wire logic [15:0] i_nvm_word_b,
	input wire logic [15:0] i_nvm_word_c,
	output logic o_nvm_wr,
	output logic [7:0] o_nvm_addr,
	output logic [15:0] o_nvm_data
);
	localparam int GW = $clog2(GCR_CYCLES + 1);
	localparam int SW = $clog2(SAMPLE_CYCLES + 1);

	typedef struct packed {
		logic [2:0] req_s;
		logic ack_tog;
		logic [15:0] rd_data;
		logic [15:0] offset;
		logic [15:0] scr_a;
		logic [15:0] scr_b;
		logic [15:0] scr_c;
		logic [15:0] temp_result;
		logic limit_event;
		logic boot;
		logic [GW-1:0] gcr_cnt;
		logic [SW-1:0] smp_cnt;
		logic sample_req;
		logic [6:0] avg_cnt;
		logic [21:0] acc;
		logic nvm_wr;
		logic [7:0] nvm_addr;
		logic [15:0] nvm_data;
	} core_state_t;

	core_state_t r;
	core_state_t next_r;
	logic link_req_tog;
	logic link_req_wr;
	logic link_req_gcr;
	logic [7:0] link_req_addr;
	logic [15:0] link_req_data;
	logic req_edge;
	logic conv_done;
	logic [21:0] acc_sum;
	logic [15:0] avg_w;
	logic [16:0] sum_w;

	function automatic logic [2:0] avg_shift(input logic [1:0] sel);
		case (sel)
			2'h0: return sensor_regs_pkg::AVG_SHIFT_1;
			2'h1: return sensor_regs_pkg::AVG_SHIFT_8;
			2'h2: return sensor_regs_pkg::AVG_SHIFT_32;
			default: return sensor_regs_pkg::AVG_SHIFT_64;
		endcase
	endfunction

	function automatic logic is_scratch(input logic [7:0] a);
		return a == sensor_regs_pkg::ADDR_SCRATCH_A || a == sensor_regs_pkg::ADDR_SCRATCH_B ||
			a == sensor_regs_pkg::ADDR_SCRATCH_C;
	endfunction

	serial_target_link u_link
	(
		.i_link_clk(i_link_clk),
		.i_rstn(i_rstn),
		.i_scl_in(i_scl_in),
		.i_sda_in(i_sda_in),
		.i_addr_strap_pin(i_addr_strap_pin),
		.i_ack_tog(r.ack_tog),
		.i_rd_data(r.rd_data),
		.o_pin_low(o_sda_out),
		.o_sda_oe(o_sda_oe),
		.o_scl_oe(o_scl_oe),
		.o_req_tog(link_req_tog),
		.o_req_wr(link_req_wr),
		.o_req_gcr(link_req_gcr),
		.o_req_addr(link_req_addr),
		.o_req_data(link_req_data)
	);
	assign o_scl_out = o_sda_out;

	always_comb
	begin
		next_r = r;
		next_r.sample_req = 1'b0;
		next_r.nvm_wr = 1'b0;
		next_r.req_s = {r.req_s[1:0], link_req_tog};
		req_edge = r.req_s[2] ^ r.req_s[1];
		conv_done = 1'b0;
		acc_sum = r.acc + {{6{i_raw_temp[15]}}, i_raw_temp};
		avg_w = 16'(acc_sum >>> avg_shift(i_avg_sel));
		sum_w = {avg_w[15], avg_w} + {r.offset[15], r.offset};
		// scratch words come up from the stored copy, not a fixed value
		if (r.boot)
		begin
			next_r.scr_a = i_nvm_word_a;
			next_r.scr_b = i_nvm_word_b;
			next_r.scr_c = i_nvm_word_c;
			next_r.boot = 1'b0;
		end
		if (r.gcr_cnt != '0)
		begin
			next_r.gcr_cnt = r.gcr_cnt - 1'b1;
			next_r.sample_req = r.gcr_cnt == GW'(1);
			next_r.smp_cnt = '0;
		end
		else if (r.smp_cnt == SW'(SAMPLE_CYCLES - 1))
		begin
			next_r.smp_cnt = '0;
			next_r.sample_req = 1'b1;
		end
		else
			next_r.smp_cnt = r.smp_cnt + 1'b1;
		if (i_raw_valid && r.gcr_cnt == '0)
		begin
			if ({1'b0, r.avg_cnt} + 8'h01 == 8'h01 << avg_shift(i_avg_sel))
			begin
				conv_done = 1'b1;
				next_r.acc = '0;
				next_r.avg_cnt = '0;
				// offset is sampled here, so a late write waits a conversion
				if (sum_w[16] != sum_w[15])
					next_r.temp_result = sum_w[16] ? sensor_regs_pkg::TEMP_MIN :
						sensor_regs_pkg::TEMP_MAX;
				else
					next_r.temp_result = sum_w[15:0];
				next_r.limit_event = $signed(next_r.temp_result) > $signed(i_high_limit) ||
					$signed(next_r.temp_result) < $signed(i_low_limit);
			end
			else
			begin
				next_r.acc = acc_sum;
				next_r.avg_cnt = r.avg_cnt + 7'h01;
			end
		end
		if (req_edge)
		begin
			next_r.ack_tog = r.req_s[1];
			case (link_req_addr)
				sensor_regs_pkg::ADDR_TEMP_RESULT: next_r.rd_data = r.temp_result;
				sensor_regs_pkg::ADDR_SCRATCH_A: next_r.rd_data = r.scr_a;
				sensor_regs_pkg::ADDR_SCRATCH_B: next_r.rd_data = r.scr_b;
				sensor_regs_pkg::ADDR_OFFSET: next_r.rd_data = r.offset;
				sensor_regs_pkg::ADDR_SCRATCH_C: next_r.rd_data = r.scr_c;
				sensor_regs_pkg::ADDR_IDENTITY: next_r.rd_data = 16'(REVISION) <<
					sensor_regs_pkg::ID_REV_LSB | 16'(PART_CODE) << sensor_regs_pkg::ID_CODE_LSB;
				default: next_r.rd_data = sensor_regs_pkg::UNMAPPED_READ;
			endcase
			if (link_req_gcr)
			begin
				next_r.offset = sensor_regs_pkg::OFFSET_RESET;
				next_r.boot = 1'b1;
				// a request launched now would be lost: the countdown restarts sampling
				next_r.sample_req = 1'b0;
				next_r.gcr_cnt = GW'(GCR_CYCLES);
				next_r.smp_cnt = '0;
				next_r.avg_cnt = '0;
				next_r.acc = '0;
			end
			else if (link_req_wr)
			begin
				if (link_req_addr == sensor_regs_pkg::ADDR_OFFSET)
					next_r.offset = link_req_data;
				if (link_req_addr == sensor_regs_pkg::ADDR_SCRATCH_A)
					next_r.scr_a = link_req_data;
				if (link_req_addr == sensor_regs_pkg::ADDR_SCRATCH_B)
					next_r.scr_b = link_req_data;
				if (link_req_addr == sensor_regs_pkg::ADDR_SCRATCH_C)
					next_r.scr_c = link_req_data;
				// locked writes stay volatile; the stored copy is untouched
				if (is_scratch(link_req_addr) && i_nvm_write_enable)
				begin
					next_r.nvm_wr = 1'b1;
					next_r.nvm_addr = link_req_addr;
					next_r.nvm_data = link_req_data;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			r <= '0;
			r.offset <= sensor_regs_pkg::OFFSET_RESET;
			r.temp_result <= sensor_regs_pkg::TEMP_RESET;
			r.boot <= 1'b1;
		end
		else
			r <= next_r;
	end

	assign o_sample_req = r.sample_req;
	assign o_limit_event = r.limit_event;
	assign o_nvm_wr = r.nvm_wr;
	assign o_nvm_addr = r.nvm_addr;
	assign o_nvm_data = r.nvm_data;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence gcr_taken;
		req_edge && link_req_gcr;
	endsequence
	sequence scratch_write;
		req_edge && !link_req_gcr && link_req_wr && is_scratch(link_req_addr);
	endsequence

	clamp_high_a: assert property ((conv_done && !sum_w[16] && sum_w[15]) |=>
		r.temp_result == 16'h7fff) else $error("positive overflow not clamped");
	clamp_low_a: assert property ((conv_done && sum_w[16] && !sum_w[15]) |=>
		r.temp_result == 16'h8000) else $error("negative overflow not clamped");
	offset_sum_a: assert property ((conv_done && sum_w[16] == sum_w[15]) |=>
		r.temp_result == $past(avg_w) + $past(r.offset)) else $error("offset not added");
	offset_late_a: assert property ((req_edge && link_req_wr && !conv_done) |=>
		$stable(r.temp_result)) else $error("result changed by offset write");
	gcr_restart_a: assert property (gcr_taken |=> (r.offset == 16'h0000 &&
		r.gcr_cnt == GW'(GCR_CYCLES) && !o_sample_req)) else $error("general reset not started");
	gcr_resume_a: assert property ((r.gcr_cnt == GW'(1) && !req_edge) |=>
		(o_sample_req ##1 !o_sample_req)) else $error("sampling not resumed after reset");
	nvm_locked_a: assert property ((scratch_write and !i_nvm_write_enable) |=>
		!o_nvm_wr) else $error("stored copy programmed while locked");
	nvm_unlocked_a: assert property ((scratch_write and i_nvm_write_enable) |=>
		(o_nvm_wr && o_nvm_data == $past(link_req_data))) else $error("stored copy missed");
endmodule

// [logic/sensor_regs_pkg.sv]
// constants for the sensor offset, scratch and identity register bank
// assumes a 10 MHz core clock and a free-running oversampling link clock
package sensor_regs_pkg;

	// register addresses
	localparam logic [7:0] ADDR_TEMP_RESULT = 8'h00;
	localparam logic [7:0] ADDR_SCRATCH_A = 8'h05;
	localparam logic [7:0] ADDR_SCRATCH_B = 8'h06;
	localparam logic [7:0] ADDR_OFFSET = 8'h07;
	localparam logic [7:0] ADDR_SCRATCH_C = 8'h08;
	localparam logic [7:0] ADDR_IDENTITY = 8'h0f;

	// reset values and field positions
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	localparam int ID_REV_LSB = 12;
	localparam int ID_CODE_LSB = 0;

	// saturation codes of the temperature format
	localparam logic [15:0] TEMP_MAX = 16'h7fff;
	localparam logic [15:0] TEMP_MIN = 16'h8000;

	// serial bus addressing
	localparam logic [6:0] TARGET_BASE = 7'h48;
	localparam logic [7:0] GCALL_WRITE = 8'h00;
	localparam logic [7:0] GCALL_RESET = 8'h06;

	// strap decode codes
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_VDD = 2'h1;
	localparam logic [1:0] STRAP_SDA = 2'h2;
	localparam logic [1:0] STRAP_SCL = 2'h3;

	// averaging select and shift amounts
	localparam logic [2:0] AVG_SHIFT_1 = 3'h0;
	localparam logic [2:0] AVG_SHIFT_8 = 3'h3;
	localparam logic [2:0] AVG_SHIFT_32 = 3'h5;
	localparam logic [2:0] AVG_SHIFT_64 = 3'h6;

	// timing
	localparam int CLK_HZ = 10000000;
	localparam int GCR_TIME_US = 1500;
	localparam int GCR_CYCLES = GCR_TIME_US * (CLK_HZ / 1000000);
	localparam int AVG8_TIME_MS = 125;
	localparam int AVG8_SAMPLES = 8;
	localparam int SAMPLE_CYCLES = AVG8_TIME_MS * (CLK_HZ / 1000) / AVG8_SAMPLES;

endpackage

// [verif/i2c_host_model.sv]
// two-wire bus master model pulling the lines through open-drain outputs
// assumes pull-ups on both lines; the bench resolves the wire levels
`timescale 1ns/1ps
module i2c_host_model
(
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_low,
	output logic o_sda_low
);
	localparam int HALF_NS = 1000;
	int hang_cnt = 0;

	initial
	begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// target may stretch the clock; the wait is bounded
	task automatic scl_rise();
		o_scl_low = 1'b0;
		for (int i = 0; i < 2000 && i_scl !== 1'b1; i++)
			#(HALF_NS / 10);
		if (i_scl !== 1'b1)
			hang_cnt++;
		#(HALF_NS);
	endtask

	task automatic start();
		o_sda_low = 1'b0;
		#(HALF_NS);
		scl_rise();
		o_sda_low = 1'b1;
		#(HALF_NS);
		o_scl_low = 1'b1;
		#(HALF_NS / 4);
	endtask

	task automatic stop();
		o_sda_low = 1'b1;
		#(HALF_NS);
		scl_rise();
		o_sda_low = 1'b0;
		#(HALF_NS);
	endtask

	// data held past the clock fall so it is never mistaken for start or stop
	task automatic bit_io(input logic b, output logic seen);
		o_sda_low = ~b;
		#(HALF_NS);
		scl_rise();
		seen = i_sda;
		o_scl_low = 1'b1;
		#(HALF_NS / 4);
	endtask

	task automatic byte_io(input logic [7:0] wr, input logic ack_out, output logic [7:0] rd,
		output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_io(wr[i], rd[i]);
		bit_io(ack_out, ack_in);
	endtask
endmodule

// [verif/sensor_offset_id_scratch_regs_tb.sv]
// self-checking bench for the offset, scratch and identity register bank
// assumes i2c_host_model on the bus and the bench acting as conversion engine
`timescale 1ns/1ps
module sensor_offset_id_scratch_regs_tb;
	localparam int SC = 50;
	localparam int GC = 20;
	localparam logic [3:0] REV = 4'h3; // arbitrary
	localparam logic [11:0] PART = 12'h2c6; // arbitrary
	localparam logic [7:0] A_RES = sensor_regs_pkg::ADDR_TEMP_RESULT;
	localparam logic [7:0] A_OFF = sensor_regs_pkg::ADDR_OFFSET;
	localparam logic [7:0] A_SB = sensor_regs_pkg::ADDR_SCRATCH_B;
	localparam logic [7:0] A_SC = sensor_regs_pkg::ADDR_SCRATCH_C;
	localparam logic [7:0] A_ID = sensor_regs_pkg::ADDR_IDENTITY;
	localparam logic [6:0] BASE = sensor_regs_pkg::TARGET_BASE;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_link_clk = 1'b0;
	logic scl, sda, strap, host_scl_low, host_sda_low;
	logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_sample_req, o_limit_event, o_nvm_wr;
	logic [7:0] o_nvm_addr, nvm_addr_seen;
	logic [15:0] o_nvm_data, nvm_data_seen;
	logic [1:0] strap_mode = 2'h0;
	logic [15:0] raw = 16'h0000;
	logic raw_valid = 1'b0;
	logic [1:0] avg_sel = 2'h0;
	logic nvm_we = 1'b0;
	logic [15:0] word_c = 16'h6a6a;
	logic [6:0] dev_addr = BASE;
	int error_cnt = 0;
	int compares = 0;
	int nvm_cnt = 0;
	int req_cnt = 0;
	logic flip = 1'b0;
	logic wob = 1'b0;

	// pull-ups: a line is low while any party pulls it
	assign scl = ~(host_scl_low | o_scl_oe);
	assign sda = ~(host_sda_low | o_sda_oe);
	assign strap = (strap_mode == 2'h0) ? 1'b0 : (strap_mode == 2'h1) ? 1'b1 :
		(strap_mode == 2'h2) ? sda : scl;

	initial forever #50 i_clk = ~i_clk;
	initial
	begin
		#7;
		forever #15 i_link_clk = ~i_link_clk;
	end

	i2c_host_model host (.i_scl(scl), .i_sda(sda), .o_scl_low(host_scl_low),
		.o_sda_low(host_sda_low));

	sensor_offset_id_scratch_regs #(.GCR_CYCLES(GC), .SAMPLE_CYCLES(SC), .REVISION(REV),
		.PART_CODE(PART)) uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk),
		.i_scl_in(scl), .i_sda_in(sda), .i_addr_strap_pin(strap), .o_scl_out(o_scl_out),
		.o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
		.i_raw_temp(raw | {14'h0000, wob & flip, 1'b0}),
		.i_raw_valid(raw_valid), .o_sample_req(o_sample_req), .i_avg_sel(avg_sel),
		.i_high_limit(16'h0200), .i_low_limit(16'hff00), .o_limit_event(o_limit_event),
		.i_nvm_write_enable(nvm_we), .i_nvm_word_a(16'h5a5a), .i_nvm_word_b(16'h3c3c),
		.i_nvm_word_c(word_c), .o_nvm_wr(o_nvm_wr), .o_nvm_addr(o_nvm_addr),
		.o_nvm_data(o_nvm_data));

	// engine answers each request one cycle later; with wob on, every other sample is +2
	always @(posedge i_clk)
	begin
		raw_valid <= o_sample_req;
		if (raw_valid)
			flip <= ~flip;
		if (o_sample_req === 1'b1)
			req_cnt++;
		if (o_nvm_wr === 1'b1)
		begin
			nvm_cnt++;
			nvm_addr_seen = o_nvm_addr;
			nvm_data_seen = o_nvm_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xbyte(input logic [7:0] b, input logic exp_ack);
		logic [7:0] rd;
		logic ack;
		host.byte_io(b, 1'b1, rd, ack);
		check("ack", {15'h0, ~exp_ack}, {15'h0, ack});
	endtask

	task automatic wr_reg(input logic [7:0] r, input logic [15:0] d);
		host.start();
		xbyte({dev_addr, 1'b0}, 1'b1);
		xbyte(r, 1'b1);
		xbyte(d[15:8], 1'b1);
		xbyte(d[7:0], 1'b1);
		host.stop();
	endtask

	task automatic rd_chk(input string what, input logic [7:0] r, input logic [15:0] exp);
		logic [15:0] d;
		logic a0, a1;
		host.start();
		xbyte({dev_addr, 1'b0}, 1'b1);
		xbyte(r, 1'b1);
		host.start();
		xbyte({dev_addr, 1'b1}, 1'b1);
		host.byte_io(8'hff, 1'b0, d[15:8], a0);
		host.byte_io(8'hff, 1'b1, d[7:0], a1);
		host.stop();
		check(what, exp, d);
	endtask

	// waits two full averages so a half-filled old one cannot count
	task automatic conv(input int n, input logic [15:0] r, input logic [15:0] off,
		input logic [15:0] exp, input logic ev);
		@(posedge i_clk);
		raw <= r;
		wr_reg(A_OFF, off);
		repeat (2 * n * SC + 20) @(posedge i_clk);
		rd_chk("result", A_RES, exp);
		check("limit event", {15'h0, ev}, {15'h0, o_limit_event});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		int c0;
		check("drive levels", 16'h0000, {14'h0000, o_scl_out, o_sda_out});
		@(negedge i_clk);
		c0 = req_cnt;
		repeat (10 * SC) @(negedge i_clk);
		check("sample requests", 16'h000a, 16'(req_cnt - c0));
		rd_chk("offset", A_OFF, 16'h0000);
		rd_chk("scratch c", A_SC, word_c);
		rd_chk("scratch b", A_SB, 16'h3c3c);
		rd_chk("identity", A_ID, {REV, PART});
		rd_chk("unmapped", 8'h0a, 16'h0000);
		$display("test reset values done");
	endtask

	task automatic t_offset();
		conv(1, 16'h0100, 16'h0010, 16'h0110, 1'b0);
		rd_chk("offset", A_OFF, 16'h0010);
		conv(1, 16'h0100, 16'hfff0, 16'h00f0, 1'b0);
		conv(1, 16'h7f00, 16'h0200, 16'h7fff, 1'b1);
		conv(1, 16'h8100, 16'hfe00, 16'h8000, 1'b1);
		rd_chk("offset", A_OFF, 16'hfe00);
		conv(1, 16'hfe00, 16'h0000, 16'hfe00, 1'b1);
		$display("test offset and clamp done");
	endtask

	task automatic t_avg();
		int n[4] = '{1, 8, 32, 64};
		logic [15:0] base;
		// alternating samples only average out when more than one is taken
		for (int s = 0; s < 4; s++)
		begin
			@(posedge i_clk);
			avg_sel <= 2'(s);
			wob <= s != 0;
			base = 16'hff80 - 16'(4 * s);
			conv(n[s], base, 16'h0000, base + 16'(s != 0), 1'b0);
		end
		$display("test averaging done");
	endtask

	// first scratch word is left alone: it carries traceability data
	task automatic t_scratch();
		wr_reg(A_SC, 16'hbeef);
		rd_chk("scratch c", A_SC, 16'hbeef);
		check("stored writes", 16'h0000, 16'(nvm_cnt));
		@(posedge i_clk);
		nvm_we <= 1'b1;
		wr_reg(A_SB, 16'h1357);
		rd_chk("scratch b", A_SB, 16'h1357);
		check("stored writes", 16'h0001, 16'(nvm_cnt));
		check("stored addr", {8'h0, A_SB}, {8'h0, nvm_addr_seen});
		check("stored data", 16'h1357, nvm_data_seen);
		wr_reg(A_ID, 16'hffff);
		rd_chk("identity", A_ID, {REV, PART});
		$display("test scratch done");
	endtask

	task automatic t_gcr();
		wr_reg(A_OFF, 16'h0123);
		@(posedge i_clk);
		word_c <= 16'h4455;
		host.start();
		xbyte(sensor_regs_pkg::GCALL_WRITE, 1'b1);
		xbyte(sensor_regs_pkg::GCALL_RESET, 1'b1);
		host.stop();
		repeat (GC + 10) @(posedge i_clk);
		rd_chk("offset", A_OFF, 16'h0000);
		rd_chk("scratch c", A_SC, 16'h4455);
		$display("test general reset done");
	endtask

	task automatic t_addr();
		for (int m = 0; m < 4; m++)
		begin
			@(posedge i_clk);
			strap_mode <= 2'(m);
			repeat (20) @(posedge i_clk);
			dev_addr = BASE + 7'(m);
			rd_chk("identity", A_ID, {REV, PART});
			host.start();
			xbyte({BASE + 7'((m + 1) % 4), 1'b0}, 1'b0);
			host.stop();
		end
		$display("test addressing done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		for (int i = 0; i < 90000 && host.hang_cnt == 0; i++)
			@(posedge i_clk);
		error_cnt++;
		$display("BAD watchdog expected 0 seen %0d", host.hang_cnt);
		summarize();
	end

	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (20) @(posedge i_clk);
		t_reset();
		t_offset();
		t_avg();
		t_scratch();
		t_gcr();
		t_addr();
		summarize();
	end
endmodule
